// [core/sec_eeprom.sv]
// serial eeprom slave: addressing, writes, erase/write timing, reads
//
// Contract
// R1: write carries a word-address byte selecting one of 256 page bytes
// R2: acknowledge word address, then acknowledge each accepted data byte
// R3: master ends byte write after one byte or six more
// R4: erase/write starts only after stop; 10 ms per byte written
// R5: no acknowledge of slave address while erase/write runs
// R6: page write of eight bytes, each acknowledged
// R7: page mode erases block 3.5 ms then writes bytes over 28 ms
// R8: page write advances only three low word-address bits
// R9: ninth and later bytes not acknowledged; whole transfer discarded
// R10: bus inputs ignored until internal write cycle completes
// R11: write-protect low lets every write through
// R12: write-protect high refuses write data into upper half; the code protects nothing when MEM_BYTES is 256
// R13: slave and word address still acknowledged when protected
// R14: read starts like write with read bit set to one
// R15: current-address, random and sequential reads supported
// R16: low eight word-address bits advance after every data byte; the code holds them on refused (protected or ninth and later) write bytes
// R17: overflow wraps within the page; page bits never change
// R18: respond only when four-bit type identifier matches
// R19: three address bits match chip pins or select a page
// R20: master nack ends read; device releases data line
// R21: master sends at most 7 bytes byte mode, 8 page mode
// R22: protected bytes are never stored in the array
`timescale 1ns/10ps
module sec_eeprom
  import sec_pkg::*;
#(
  parameter int         MEM_BYTES   = 1024,
  // arbitrary value, set per product
  parameter logic [3:0] DEV_TYPE_ID = 4'h6,
  parameter int         BYTE_CYC    = EW_BYTE_CYC,
  parameter int         ERASE_CYC   = PAGE_ERASE_CYC,
  parameter int         PBYTE_CYC   = PAGE_BYTE_CYC
) (
  input  wire logic SYS_CLK,
  input  wire logic NRST,
  input  wire logic SCL_IN,
  input  wire logic SDA_IN,
  output logic      SDA_OUT,
  output logic      SDA_OE_N,
  input  wire logic WRITE_PROTECT,
  input  wire logic CHIP_SELECT_BIT0,
  input  wire logic CHIP_SELECT_BIT1,
  input  wire logic CHIP_SELECT_BIT2,
  output logic      BUSY
);

  localparam int AW        = $clog2(MEM_BYTES);
  localparam int PAGE_BITS = AW - 8;

  // elaboration checks: array and timer cannot serve other values
  if (MEM_BYTES != 256 && MEM_BYTES != 512 && MEM_BYTES != 1024) begin
    $error("MEM_BYTES must be 256, 512 or 1024");
  end
  if (BYTE_CYC < 1 || ERASE_CYC < 1 || PBYTE_CYC < 1 ||
      BYTE_CYC >= 2**TMR_W || ERASE_CYC >= 2**TMR_W ||
      PBYTE_CYC >= 2**TMR_W) begin
    $error("cycle counts out of timer range");
  end

  localparam logic [TMR_W-1:0] BYTE_T  = TMR_W'(BYTE_CYC - 1);
  localparam logic [TMR_W-1:0] ERASE_T = TMR_W'(ERASE_CYC - 1);
  localparam logic [TMR_W-1:0] PBYTE_T = TMR_W'(PBYTE_CYC - 1);
  localparam logic [2:0]  CS_MASK   = 3'(3'b111 << PAGE_BITS);
  localparam logic [MAX_ADDR_W-1:0] UPPER_HALF =
    MAX_ADDR_W'(MEM_BYTES / 2);

  typedef struct packed {
    logic [LANES-1:0] s1;
    logic [LANES-1:0] s2;
    logic             scl_p;
    logic             sda_p;
    sec_st_t          st;
    logic [3:0]       bitc;
    logic [7:0]       sh;
    logic             ack_slot;
    logic             ack_ok;
    logic             rw;
    logic [2:0]       page;
    logic [7:0]       waddr;
    logic [7:0]       base;
    logic [63:0]      wbuf;
    logic [3:0]       cnt;
    logic             over;
    sec_pst_t         pst;
    logic [2:0]       pidx;
    logic [TMR_W-1:0] tmr;
    logic             busy;
    logic             oe_n;
    logic             sda_o;
    logic             we;
    logic [MAX_ADDR_W-1:0] pa;
    logic [7:0]       wd;
  } sec_state_t;

  sec_state_t s_reg;
  sec_state_t s_next;

  logic [7:0]            mem_rd;
  logic [MAX_ADDR_W-1:0] rd_full;
  logic [MAX_ADDR_W-1:0] mem_full;

  assign rd_full  = {s_reg.page, s_reg.waddr};
  // strobe, not busy: busy drops on the edge that issues the last write
  assign mem_full = s_reg.we ? s_reg.pa : rd_full;

  sec_mem #(
    .MEM_BYTES(MEM_BYTES)
  ) u_mem (
    .clk  (SYS_CLK),
    .we   (s_reg.we),
    .addr (mem_full[AW-1:0]),
    .wdata(s_reg.wd),
    .rdata(mem_rd)
  );

  logic       scl;
  logic       sda;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic [2:0] cs_pins;
  logic       addr_hit;
  logic       prot_hit;

  always_comb begin
    scl      = s_reg.s2[LN_SCL];
    sda      = s_reg.s2[LN_SDA];
    cs_pins  = s_reg.s2[LN_CS +: 3];
    rise     = scl & ~s_reg.scl_p;
    fall     = ~scl & s_reg.scl_p;
    start    = scl & s_reg.scl_p & s_reg.sda_p & ~sda;
    stop     = scl & s_reg.scl_p & ~s_reg.sda_p & sda;
    addr_hit = (s_reg.sh[7:4] == DEV_TYPE_ID) &&                 // see R18
               (((s_reg.sh[3:1] ^ cs_pins) & CS_MASK) == 3'b000); // see R19
    prot_hit = s_reg.s2[LN_WP] && (MEM_BYTES > PAGE_SIZE) &&     // see R11
               (rd_full >= UPPER_HALF);                          // see R12
  end

  always_comb begin
    s_next       = s_reg;
    s_next.s1    = {CHIP_SELECT_BIT2, CHIP_SELECT_BIT1, CHIP_SELECT_BIT0,
                    WRITE_PROTECT, SDA_IN, SCL_IN};
    s_next.s2    = s_reg.s1;
    s_next.scl_p = scl;
    s_next.sda_p = sda;
    s_next.we    = 1'b0;

    // erase/write sequencer; owns the array while busy
    case (s_reg.pst)
      PS_ERASE: begin
        if (s_reg.tmr == '0) begin
          s_next.pst = PS_WRITE;                      // see R7
          s_next.tmr = PBYTE_T;
        end else begin
          s_next.tmr = s_reg.tmr - 1'b1;
        end
      end
      PS_WRITE: begin
        if (s_reg.tmr == '0) begin
          s_next.we   = 1'b1;
          s_next.wd   = s_reg.wbuf[{s_reg.pidx, 3'b000} +: 8];
          s_next.pa   = {s_reg.page, s_reg.base[7:3],
                         3'(s_reg.base[2:0] + s_reg.pidx)}; // see R8
          s_next.pidx = s_reg.pidx + 1'b1;
          s_next.tmr  = (s_reg.cnt == 4'(PAGE_BYTES)) ? PBYTE_T : BYTE_T;
          if ({1'b0, s_reg.pidx} + 4'd1 == s_reg.cnt) begin
            s_next.pst  = PS_IDLE;
            s_next.busy = 1'b0;
            s_next.cnt  = '0;
          end
        end else begin
          s_next.tmr = s_reg.tmr - 1'b1;
        end
      end
      default: begin
        s_next.pst = PS_IDLE;
      end
    endcase

    // while programming the line is never driven and nothing is decoded
    if (s_reg.busy) begin                             // see R5 R10
      s_next.st   = ST_IDLE;
      s_next.oe_n = 1'b1;
    end else if (stop) begin
      s_next.st       = ST_IDLE;
      s_next.ack_slot = 1'b0;
      s_next.oe_n     = 1'b1;
      if (s_reg.st == ST_WDATA && s_reg.cnt != '0 && !s_reg.over) begin
        s_next.busy = 1'b1;                           // see R4
        s_next.pidx = '0;
        if (s_reg.cnt == 4'(PAGE_BYTES)) begin
          s_next.pst = PS_ERASE;                      // see R7
          s_next.tmr = ERASE_T;
        end else begin
          s_next.pst = PS_WRITE;                      // see R4
          s_next.tmr = BYTE_T;
        end
      end else begin
        s_next.cnt = '0;                              // see R9
      end
    end else if (start) begin
      // repeated start drops any uncommitted write data
      s_next.st       = ST_ADDR;
      s_next.bitc     = '0;
      s_next.ack_slot = 1'b0;
      s_next.oe_n     = 1'b1;
      s_next.cnt      = '0;
      s_next.over     = 1'b0;
    end else if (s_reg.st != ST_IDLE) begin
      if (rise) begin
        if (s_reg.ack_slot) begin
          s_next.ack_ok = ~sda;                       // see R20
        end else begin
          s_next.sh   = {s_reg.sh[6:0], sda};
          s_next.bitc = s_reg.bitc + 1'b1;
        end
      end else if (fall) begin
        if (!s_reg.ack_slot && s_reg.bitc == 4'(BITS_PER_BYTE)) begin
          s_next.ack_slot = 1'b1;
          s_next.oe_n     = 1'b1;
          case (s_reg.st)
            ST_ADDR: begin
              if (addr_hit) begin
                s_next.oe_n = 1'b0;                   // see R13
                s_next.rw   = s_reg.sh[0];            // see R14
                s_next.page = s_reg.sh[3:1] & ~CS_MASK; // see R19
              end else begin
                s_next.st = ST_IDLE;
              end
            end
            ST_WORD: begin
              s_next.oe_n  = 1'b0;                    // see R2 R13
              s_next.waddr = s_reg.sh;                // see R1
            end
            ST_WDATA: begin
              if (s_reg.cnt == 4'(PAGE_BYTES) || s_reg.over) begin
                s_next.over = 1'b1;                   // see R9
              end else if (!prot_hit) begin           // see R22
                s_next.oe_n = 1'b0;                   // see R2 R6
                s_next.wbuf[{s_reg.cnt[2:0], 3'b000} +: 8] = s_reg.sh;
                if (s_reg.cnt == '0) begin
                  s_next.base = s_reg.waddr;
                end
                s_next.cnt   = s_reg.cnt + 1'b1;
                s_next.waddr = s_reg.waddr + 1'b1;    // see R16 R17
              end
            end
            ST_RDATA: begin
              s_next.waddr = s_reg.waddr + 1'b1;      // see R16 R17
            end
            default: begin
              s_next.st = ST_IDLE;
            end
          endcase
        end else if (s_reg.ack_slot) begin
          s_next.ack_slot = 1'b0;
          s_next.bitc     = '0;
          s_next.oe_n     = 1'b1;
          case (s_reg.st)
            ST_ADDR: begin
              if (s_reg.rw) begin
                s_next.st   = ST_RDATA;               // see R15
                s_next.sh   = mem_rd;
                s_next.oe_n = mem_rd[7];
              end else begin
                s_next.st = ST_WORD;
              end
            end
            ST_WORD: begin
              s_next.st = ST_WDATA;
            end
            ST_RDATA: begin
              if (s_reg.ack_ok) begin
                s_next.sh   = mem_rd;                 // see R15
                s_next.oe_n = mem_rd[7];
              end else begin
                s_next.st = ST_IDLE;                  // see R20
              end
            end
            default: begin
            end
          endcase
        end else if (s_reg.st == ST_RDATA) begin
          // open drain: a one is sent by letting go of the line
          s_next.oe_n = s_reg.sh[7];
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      s_reg <= '0;
      s_reg.oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign SDA_OUT  = s_reg.sda_o;
  assign SDA_OE_N = s_reg.oe_n;
  assign BUSY     = s_reg.busy;

endmodule

// [core/sec_pkg.sv]
// shared constants and types for the serial eeprom access block
package sec_pkg;

  // bus sampling clock
  localparam int CLK_MHZ          = 20;

  // erase/write timing, in microseconds as specified
  localparam int EW_BYTE_US       = 10000;
  localparam int PAGE_ERASE_US    = 3500;
  localparam int PAGE_WRITE_US    = 28000;
  localparam int PAGE_BYTES       = 8;

  // derived cycle counts at the bus sampling clock
  localparam int EW_BYTE_CYC      = EW_BYTE_US * CLK_MHZ;
  localparam int PAGE_ERASE_CYC   = PAGE_ERASE_US * CLK_MHZ;
  localparam int PAGE_BYTE_CYC    = PAGE_WRITE_US * CLK_MHZ / PAGE_BYTES;

  // structure of the bus transfer
  localparam int BITS_PER_BYTE    = 8;
  localparam int TMR_W            = 20;
  localparam int MAX_ADDR_W       = 11;
  localparam int PAGE_SIZE        = 256;

  // synchroniser lane positions
  localparam int LN_SCL           = 0;
  localparam int LN_SDA           = 1;
  localparam int LN_WP            = 2;
  localparam int LN_CS            = 3;
  localparam int LANES            = 6;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_WORD  = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100
  } sec_st_t;

  typedef enum logic [1:0] {
    PS_IDLE  = 2'b00,
    PS_ERASE = 2'b01,
    PS_WRITE = 2'b10
  } sec_pst_t;

endpackage

// [core/sec_mem.sv]
// byte-wide nonvolatile array model with registered read data
`timescale 1ns/10ps
module sec_mem #(
  parameter int MEM_BYTES = 1024
) (
  input  wire logic                         clk,
  input  wire logic                         we,
  input  wire logic [$clog2(MEM_BYTES)-1:0] addr,
  input  wire logic [7:0]                   wdata,
  output logic      [7:0]                   rdata
);

  logic [7:0] cells [MEM_BYTES];

  // no reset: array contents survive like the real cells
  always_ff @(posedge clk) begin
    if (we) begin
      cells[addr] <= wdata;
    end
    rdata <= cells[addr];
  end

endmodule

// [bench/sec_eeprom_properties.sv]
// pin-level checks on the serial eeprom slave
`timescale 1ns/10ps
module sec_eeprom_chk
  import sec_pkg::*;
#(
  parameter int BYTE_CYC  = EW_BYTE_CYC,
  parameter int ERASE_CYC = PAGE_ERASE_CYC,
  parameter int PBYTE_CYC = PAGE_BYTE_CYC
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N,
  input wire logic BUSY
);
  localparam int PG = ERASE_CYC + 8 * PBYTE_CYC;
  logic        sda_d;
  logic [7:0]  since_stop;
  logic [31:0] busy_cnt;
  logic [15:0] low_cnt;
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      sda_d      <= 1'b1;
      since_stop <= 8'hff;
      busy_cnt   <= 32'h0000_0000;
      low_cnt    <= 16'h0000;
    end else begin
      sda_d      <= SDA_IN;
      // raw stop; the slave sees it a few clocks later
      since_stop <= (SCL_IN & SDA_IN & ~sda_d) ? 8'h00
                    : since_stop + {7'h00, ~&since_stop};
      busy_cnt   <= BUSY ? busy_cnt + 32'h0000_0001 : 32'h0000_0000;
      low_cnt    <= SDA_OE_N ? 16'h0000 : low_cnt + 16'h0001;
    end
  end
  default clocking dcb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);
  a_reset_quiet: assert property (
    $rose(NRST) |-> (SDA_OE_N && !BUSY) [*4]) else $error("drive at reset");
  a_busy_silent: assert property (BUSY |-> SDA_OE_N)
    else $error("driven while busy");
  a_drive_low: assert property (!SDA_OE_N |-> !SDA_OUT)
    else $error("driven level high");
  a_busy_after_stop: assert property (
    $rose(BUSY) |-> since_stop <= 8'h0c) else $error("busy without stop");
  a_busy_holds: assert property ($rose(BUSY) |-> BUSY [*8])
    else $error("busy too short");
  a_busy_length: assert property (
    $fell(BUSY) && busy_cnt != 32'h0000_0000 |->
      ((busy_cnt + 1) % BYTE_CYC <= 2 && busy_cnt <= 7 * BYTE_CYC + 1)
      || (busy_cnt >= PG - 1 && busy_cnt <= PG + 1))
    else $error("busy length wrong");
  a_steady_high: assert property (
    SCL_IN && $past(SCL_IN) && $past(SCL_IN, 2) |-> $stable(SDA_OE_N))
    else $error("data moved while clock high");
  a_drive_bounded: assert property (low_cnt <= 16'h0048)
    else $error("data line held too long");
endmodule
bind sec_eeprom sec_eeprom_chk #(
  .BYTE_CYC(BYTE_CYC), .ERASE_CYC(ERASE_CYC), .PBYTE_CYC(PBYTE_CYC)
) chk (
  .SYS_CLK(SYS_CLK), .NRST(NRST), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .BUSY(BUSY)
);

// [bench/sec_bus_master.sv]
// behavioural bus master on the eeprom's serial pins
`timescale 1ns/10ps
module sec_bus_master (
  input  wire logic SYS_CLK,
  input  wire logic SDA,
  output logic      SCL,
  output logic      SDA_DRV
);
  logic [7:0] obs, d;
  event       got;
  logic       r;
  initial begin
    SCL = 1'b1;
    SDA_DRV = 1'b1;
  end
  // a quarter of the 400 ns bit; lines move just after a clock edge
  task automatic s(input logic c, input logic v);
    repeat (2) @(posedge SYS_CLK);
    #1;
    SCL = c;
    SDA_DRV = v;
  endtask
  // extra quarter first: the slave may still pull after SCL falls
  task automatic start();
    s(SCL, SDA_DRV);
    s(SCL, 1'b1);
    s(1'b1, 1'b1);
    s(1'b1, 1'b0);
    s(1'b0, 1'b0);
  endtask
  task automatic stop();
    s(1'b0, 1'b0);
    s(1'b1, 1'b0);
    s(1'b1, 1'b1);
  endtask
  task automatic bitx(input logic b, output logic q);
    s(1'b0, b);
    s(1'b1, b);
    s(1'b1, b);
    q = SDA;
    s(1'b0, b);
  endtask
  // msb first; rd set: hand on data, else the slave's ack bit
  task automatic xfer(input logic [7:0] b, input logic a, input logic rd);
    for (int i = 7; i >= 0; i--) bitx(b[i], d[i]);
    bitx(a, r);
    obs = rd ? d : {7'h00, r};
    -> got;
  endtask
endmodule

// [bench/sec_eeprom_test.sv]
// self-checking bench for the serial eeprom slave
`timescale 1ns/10ps
module sec_eeprom_test;
  localparam logic [3:0] TYPE_ID = 4'h6; // arbitrary value
  // shortened erase/write timing keeps the run short
  localparam int BYTE_C  = 200;
  localparam int ERASE_C = 70;
  localparam int PBYTE_C = 70;
  logic       clk, nrst, wp, scl, sda_m, sda_out, sda_oe_n, busy;
  logic [2:0] cs;
  logic [7:0] e, exp_q[$], ref_mem[1024], dq[16];
  logic [9:0] cur_a;
  int         mismatches, total_checks, seed;
  int         busy_base, busy_exp;
  int         busy_cyc = 0;
  wire        sda = sda_m & (sda_oe_n | sda_out);
`define CHK(a, b) begin \
    total_checks++; \
    if ((a) !== (b)) begin \
      mismatches++; \
      $display("ERROR %0t got %h exp %h", $time, a, b); \
    end \
  end
  sec_eeprom #(.DEV_TYPE_ID(TYPE_ID), .BYTE_CYC(BYTE_C),
    .ERASE_CYC(ERASE_C), .PBYTE_CYC(PBYTE_C)) dut (
    .SYS_CLK(clk), .NRST(nrst), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .WRITE_PROTECT(wp),
    .CHIP_SELECT_BIT0(cs[0]), .CHIP_SELECT_BIT1(cs[1]),
    .CHIP_SELECT_BIT2(cs[2]), .BUSY(busy));
  sec_bus_master m (.SYS_CLK(clk), .SDA(sda), .SCL(scl), .SDA_DRV(sda_m));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic tx(input logic [7:0] b, input logic nak);
    exp_q.push_back({7'h00, nak});
    m.xfer(b, 1'b1, 1'b0);
  endtask
  task automatic sel(input logic [1:0] pg, input logic rd, input logic nak);
    m.start();
    tx({TYPE_ID, cs[2], pg, rd}, nak);
  endtask
  // bytes from index lim on are expected refused; st: bytes get stored
  task automatic wr(input logic [1:0] pg, input logic [7:0] wa,
                    input int n, input int lim, input logic st);
    for (int i = 0; i < n; i++) dq[i] = 8'($random(seed));
    busy_base = busy_cyc;
    busy_exp  = !st ? 0 : (n == 8) ? ERASE_C + 8 * PBYTE_C : n * BYTE_C;
    sel(pg, 1'b0, 1'b0);
    tx(wa, 1'b0);
    for (int i = 0; i < n; i++) tx(dq[i], i >= lim);
    m.stop();
    for (int i = 0; i < n && st; i++)
      ref_mem[{pg, wa[7:3], 3'(wa[2:0] + i)}] = dq[i];
  endtask
  task automatic settle();
    repeat (8) @(posedge clk);
    for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge clk);
    #1;
    `CHK(busy, 1'b0)
    `CHK(busy_cyc - busy_base, busy_exp)
  endtask
  task automatic cur(input int n);
    sel(cur_a[9:8], 1'b1, 1'b0);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(ref_mem[cur_a]);
      m.xfer(8'hff, i == n - 1, 1'b1);
      cur_a[7:0] = cur_a[7:0] + 8'h01;
    end
    m.stop();
  endtask
  task automatic rd(input logic [1:0] pg, input logic [7:0] wa, input int n);
    sel(pg, 1'b0, 1'b0);
    tx(wa, 1'b0);
    cur_a = {pg, wa};
    cur(n);
  endtask
  task automatic conclude();
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial forever begin
    @(m.got);
    e = exp_q.pop_front();
    `CHK(m.obs, e)
  end
  // busy sampled away from the edge that moves it
  initial forever begin
    @(negedge clk);
    if (busy === 1'b1) busy_cyc++;
  end
  initial begin
    #3000000;
    mismatches++;
    conclude();
  end
  initial begin
    nrst = 1'b0;
    wp = 1'b0;
    seed = 32'he692;
    cs = 3'($random(seed));
    mismatches = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    `CHK({sda_oe_n, busy}, 2'b10)
    repeat (8) @(posedge clk);
    m.start();
    tx({~TYPE_ID, cs[2], 3'h0}, 1'b1);
    m.stop();
    m.start();
    tx({TYPE_ID, ~cs[2], 3'h0}, 1'b1);
    m.stop();
    wr(2'd1, 8'h00, 1, 8, 1'b1);
    sel(2'd1, 1'b0, 1'b1);
    m.stop();
    settle();
    wr(2'd0, 8'h06, 7, 8, 1'b1);
    settle();
    wr(2'd1, 8'hfd, 8, 8, 1'b1);
    settle();
    wr(2'd1, 8'hf8, 9, 8, 1'b0);
    settle();
    wr(2'd2, 8'h40, 1, 8, 1'b1);
    settle();
    wp = 1'b1;
    wr(2'd2, 8'h40, 2, 0, 1'b0);
    settle();
    wr(2'd0, 8'h20, 1, 8, 1'b1);
    settle();
    rd(2'd2, 8'h40, 1);
    rd(2'd0, 8'h20, 1);
    rd(2'd1, 8'hf8, 8);
    cur(1);
    rd(2'd0, 8'h06, 2);
    rd(2'd0, 8'h00, 5);
    conclude();
  end
endmodule
